//--- rtl/stm_pkg.sv
/*
 * Package for the standard timer module core: register offsets, control
 * field positions, mode and clock-select codes and bus-side structs.
 * Assumes a single 250 MHz clock and an AXI4-Lite register master.
 */
//
// Behaviour
// - Sixteen-bit counter counts up on selected clock
// - Period compares high byte; compare A all bits
// - Overflow or selected match clears; only a match raises interrupt
// - On rising edge clears count; off holds it
// - Count readable only; writes never load it
// - Pause holds count; release resumes counting
// - Clock select codes; reserved codes stop counter
// - Compare mode on-edge restores initial pin level
// - Control zero low three bits read zero
// - Mode field selects compare, PWM, timer/counter
// - Compare A match: none, low, high, toggle
// - PWM field: inactive, active, PWM, single pulse
// - Polarity bit inverts pin in every mode; timer mode leaves it undriven
// - Period/duty select swaps comparator roles in PWM
// - Clear select picks compare A or period/overflow
// - Period zero gives full 65536 count
package stm_pkg;
    // Register byte addresses.
    localparam logic [7:0] STM_ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] STM_ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] STM_ADDR_CNTL = 8'h08;
    localparam logic [7:0] STM_ADDR_CNTH = 8'h0C;
    localparam logic [7:0] STM_ADDR_CMPAL = 8'h10;
    localparam logic [7:0] STM_ADDR_CMPAH = 8'h14;
    localparam logic [7:0] STM_ADDR_PER = 8'h18;
    localparam logic [7:0] STM_ADDR_IRQ_STAT = 8'h1C;
    localparam logic [7:0] STM_ADDR_IRQ_EN = 8'h20;
    localparam logic [7:0] STM_ADDR_IRQ_CLR = 8'h24;
    // Field positions.
    localparam int STM_C0_PAUSE = 7;
    localparam int STM_C0_CKS_LO = 4;
    localparam int STM_C0_ON = 3;
    localparam int STM_C1_MODE_LO = 6;
    localparam int STM_C1_FUNC_LO = 4;
    localparam int STM_C1_OC = 3;
    localparam int STM_C1_POL = 2;
    localparam int STM_C1_DPX = 1;
    localparam int STM_C1_CCLR = 0;
    localparam logic [7:0] STM_C0_MASK = 8'hF8;
    localparam logic [7:0] STM_RESET_BYTE = 8'h00;
    localparam logic [15:0] STM_CNT_MAX = 16'hFFFF;
    localparam logic [7:0] STM_PER_FULL = 8'h00;
    // Divider ratios of the prescaled clock sources.
    localparam int STM_DIV_SYS = 4;
    localparam int STM_DIV_H16 = 16;
    localparam int STM_DIV_H64 = 64;
    localparam logic [1:0] STM_RESP_OKAY = 2'b00;
    localparam logic [1:0] STM_RESP_SLVERR = 2'b10;
    // Interrupt status bits: compare A match, period match.
    localparam int STM_IRQ_A = 0;
    localparam int STM_IRQ_P = 1;
    localparam int STM_IRQ_W = 2;

    typedef enum logic [1:0] {
        STM_MODE_CMP = 2'b00,
        STM_MODE_UNDEF = 2'b01,
        STM_MODE_PWM = 2'b10,
        STM_MODE_TMR = 2'b11
    } stm_mode_t;

    typedef enum logic [1:0] {
        STM_FN_0 = 2'b00,
        STM_FN_1 = 2'b01,
        STM_FN_2 = 2'b10,
        STM_FN_3 = 2'b11
    } stm_func_t;

    typedef enum logic [2:0] {
        STM_CK_SYS4 = 3'b000,
        STM_CK_SYS = 3'b001,
        STM_CK_H16 = 3'b010,
        STM_CK_H64 = 3'b011,
        STM_CK_TBC = 3'b100
    } stm_cks_t;

    // AXI4-Lite master-to-slave bundle.
    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } stm_axi_req_t;

    // AXI4-Lite slave-to-master bundle.
    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } stm_axi_rsp_t;
endpackage

//--- rtl/stm_core.sv
/*
 * Standard timer module core: up counter, clock selection, two
 * comparators, pin output logic, interrupt flags and AXI4-Lite slave.
 * Assumes time_base_clk_i and high_clk_i are single-cycle enable pulses
 * synchronous to clk_i, which is the system clock.
 */
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/10ps
module stm_core (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic high_clk_i,
    input wire logic time_base_clk_i,
    input wire stm_pkg::stm_axi_req_t axi_req_i,
    output stm_pkg::stm_axi_rsp_t axi_rsp_o,
    output logic timer_pin_o,
    output logic timer_pin_oe_n_o,
    output logic irq_o
);
    import stm_pkg::*;

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] cmpa_lo;
    logic [7:0] cmpa_hi;
    logic [7:0] period;
    localparam int IRQ_W_L = STM_IRQ_W;
    logic [IRQ_W_L-1:0] irq_stat;
    logic [IRQ_W_L-1:0] irq_en;
    logic [15:0] count;
    logic on_q;
    logic pin_raw;
    logic pulse_done;
    logic [5:0] presc;
    logic [3:0] hpresc;
    logic [5:0] h64;
    stm_axi_rsp_t rsp;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    wire pause_bit = ctrl0[STM_C0_PAUSE];
    wire on_off_bit = ctrl0[STM_C0_ON];
    wire [2:0] clock_select_field = ctrl0[STM_C0_CKS_LO +: 3];
    wire [1:0] mode_field = ctrl1[STM_C1_MODE_LO +: 2];
    wire [1:0] output_function_field = ctrl1[STM_C1_FUNC_LO +: 2];
    wire output_control_bit = ctrl1[STM_C1_OC];
    wire output_polarity_bit = ctrl1[STM_C1_POL];
    wire period_duty_select_bit = ctrl1[STM_C1_DPX];
    wire counter_clear_select_bit = ctrl1[STM_C1_CCLR];
    wire [15:0] compare_a_value = {cmpa_hi, cmpa_lo};
    wire on_rise = on_off_bit && !on_q;
    wire is_pwm = (mode_field == STM_MODE_PWM);
    wire is_cmp = (mode_field == STM_MODE_CMP);

    // clock source select: reserved codes give no tick.
    wire sys4_tick = (presc[1:0] == 2'(STM_DIV_SYS - 1));
    wire h16_tick = high_clk_i && (hpresc == 4'(STM_DIV_H16 - 1));
    wire h64_tick = high_clk_i && (h64 == 6'(STM_DIV_H64 - 1));
    logic tick_sel;
    always_comb begin
        unique case (clock_select_field)
            STM_CK_SYS4: tick_sel = sys4_tick;
            STM_CK_SYS: tick_sel = 1'b1;
            STM_CK_H16: tick_sel = h16_tick;
            STM_CK_H64: tick_sel = h64_tick;
            STM_CK_TBC: tick_sel = time_base_clk_i;
            default: tick_sel = 1'b0;
        endcase
    end
    wire tick = tick_sel && on_off_bit && !pause_bit && !on_rise;

    wire match_a = tick && (count == compare_a_value);
    // The match sits on the last clock of the block, so value N spans 256*N clocks.
    wire match_p = tick && (count[15:8] == 8'(period - 8'h01)) && (period != STM_PER_FULL)
        && (count[7:0] == 8'hFF);
    wire ovf = tick && (count == STM_CNT_MAX);
    // clear select, period source in PWM, zero period.
    wire clr_by_a = is_pwm ? period_duty_select_bit : counter_clear_select_bit;
    wire do_clear = clr_by_a ? match_a : (match_p || ovf);
    wire [15:0] duty_cmp = period_duty_select_bit ? {period, 8'h00} : compare_a_value;
    wire pwm_active = (count < duty_cmp);

    // ------------------------------------------------------------
    // Prescalers
    // ------------------------------------------------------------
    // Free-running dividers so that a source change never waits long.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            presc <= 6'h00;
            hpresc <= 4'h0;
            h64 <= 6'h00;
        end else begin
            presc <= presc + 6'h01;
            if (high_clk_i) begin
                hpresc <= hpresc + 4'h1;
                h64 <= h64 + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // count up; clear on match; clear on rise.
    // no bus path writes the counter.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= 16'h0000;
            on_q <= 1'b0;
        end else begin
            on_q <= on_off_bit;
            if (on_rise || do_clear) begin
                count <= 16'h0000;
            end else if (tick) begin
                count <= count + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Output pin
    // ------------------------------------------------------------
    logic next_pin;
    always_comb begin
        next_pin = pin_raw;
        if (is_cmp) begin
            if (on_rise) begin
                next_pin = output_control_bit;
            end else if (match_a) begin
                unique case (output_function_field)
                    STM_FN_0: next_pin = pin_raw;
                    STM_FN_1: next_pin = 1'b0;
                    STM_FN_2: next_pin = 1'b1;
                    STM_FN_3: next_pin = !pin_raw;
                endcase
            end
        end else if (is_pwm) begin
            // PWM functions, active level from output control bit.
            unique case (output_function_field)
                STM_FN_0: next_pin = !output_control_bit;
                STM_FN_1: next_pin = output_control_bit;
                STM_FN_2: next_pin = pwm_active ? output_control_bit : !output_control_bit;
                STM_FN_3: next_pin = (pwm_active && !pulse_done && on_off_bit)
                    ? output_control_bit : !output_control_bit;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_raw <= 1'b0;
            pulse_done <= 1'b0;
            timer_pin_o <= 1'b0;
            timer_pin_oe_n_o <= 1'b1;
        end else begin
            pin_raw <= next_pin;
            // Single pulse ends at the first duty match and rearms on start.
            if (on_rise) begin
                pulse_done <= 1'b0;
            end else if (tick && !pwm_active) begin
                pulse_done <= 1'b1;
            end
            // polarity inversion; pin undriven in timer mode.
            timer_pin_o <= next_pin ^ output_polarity_bit;
            timer_pin_oe_n_o <= (mode_field == STM_MODE_TMR) || (mode_field == STM_MODE_UNDEF);
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // events set sticky flags; the set wins over a clear.
    // Period flag is suppressed when compare A clears (outside PWM).
    wire [IRQ_W_L-1:0] irq_set = {match_p && (is_pwm || !counter_clear_select_bit), match_a};
    wire aw_go = axi_req_i.awvalid && axi_req_i.wvalid && !rsp.bvalid;
    wire wr_lane0 = aw_go && axi_req_i.wstrb[0];
    wire [7:0] wbyte = axi_req_i.wdata[7:0];
    wire [7:0] waddr = axi_req_i.awaddr;
    wire [IRQ_W_L-1:0] irq_clr = (wr_lane0 && waddr == STM_ADDR_IRQ_CLR)
        ? wbyte[IRQ_W_L-1:0] : '0;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_stat <= '0;
            irq_o <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            irq_o <= |(((irq_stat & ~irq_clr) | irq_set) & irq_en);
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    wire wr_hit = (waddr == STM_ADDR_CTRL0) || (waddr == STM_ADDR_CTRL1)
        || (waddr == STM_ADDR_CMPAL) || (waddr == STM_ADDR_CMPAH)
        || (waddr == STM_ADDR_PER) || (waddr == STM_ADDR_IRQ_EN)
        || (waddr == STM_ADDR_IRQ_CLR) || (waddr == STM_ADDR_CNTL)
        || (waddr == STM_ADDR_CNTH) || (waddr == STM_ADDR_IRQ_STAT);
    wire ar_go = axi_req_i.arvalid && !rsp.rvalid;
    logic [7:0] rbyte;
    logic rd_hit;
    // low control bits read zero; count readable.
    always_comb begin
        rd_hit = 1'b1;
        unique case (axi_req_i.araddr)
            STM_ADDR_CTRL0: rbyte = ctrl0 & STM_C0_MASK;
            STM_ADDR_CTRL1: rbyte = ctrl1;
            STM_ADDR_CNTL: rbyte = count[7:0];
            STM_ADDR_CNTH: rbyte = count[15:8];
            STM_ADDR_CMPAL: rbyte = cmpa_lo;
            STM_ADDR_CMPAH: rbyte = cmpa_hi;
            STM_ADDR_PER: rbyte = period;
            STM_ADDR_IRQ_STAT: rbyte = 8'(irq_stat);
            STM_ADDR_IRQ_EN: rbyte = 8'(irq_en);
            STM_ADDR_IRQ_CLR: rbyte = STM_RESET_BYTE;
            default: begin
                rbyte = STM_RESET_BYTE;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Write and read both complete in the cycle after acceptance.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl0 <= STM_RESET_BYTE;
            ctrl1 <= STM_RESET_BYTE;
            cmpa_lo <= STM_RESET_BYTE;
            cmpa_hi <= STM_RESET_BYTE;
            period <= STM_RESET_BYTE;
            irq_en <= '0;
            rsp <= '0;
        end else begin
            rsp.awready <= aw_go;
            rsp.wready <= aw_go;
            rsp.arready <= ar_go;
            if (aw_go) begin
                rsp.bvalid <= 1'b1;
                rsp.bresp <= wr_hit ? STM_RESP_OKAY : STM_RESP_SLVERR;
            end else if (axi_req_i.bready) begin
                rsp.bvalid <= 1'b0;
            end
            if (ar_go) begin
                rsp.rvalid <= 1'b1;
                rsp.rdata <= {24'h000000, rbyte};
                rsp.rresp <= rd_hit ? STM_RESP_OKAY : STM_RESP_SLVERR;
            end else if (axi_req_i.rready) begin
                rsp.rvalid <= 1'b0;
            end
            if (wr_lane0) begin
                unique case (waddr)
                    STM_ADDR_CTRL0: ctrl0 <= wbyte & STM_C0_MASK;
                    STM_ADDR_CTRL1: ctrl1 <= wbyte;
                    STM_ADDR_CMPAL: cmpa_lo <= wbyte;
                    STM_ADDR_CMPAH: cmpa_hi <= wbyte;
                    STM_ADDR_PER: period <= wbyte;
                    STM_ADDR_IRQ_EN: irq_en <= wbyte[IRQ_W_L-1:0];
                    default: ;
                endcase
            end
        end
    end
    // Ready rises one cycle after valid, with the response, straight from the flops.
    assign axi_rsp_o = rsp;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_on_rise_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        on_rise |=> count == 16'h0000) else $error("count not cleared on enable");
    a_off_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!on_off_bit && !on_rise) |=> $stable(count)) else $error("count moved while off");
    a_pause_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (pause_bit && !on_rise) |=> $stable(count)) else $error("count moved in pause");
    a_count_up: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (tick && !do_clear) |=> count == $past(count) + 16'h0001) else $error("bad count step");
    a_reserved_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (clock_select_field > 3'b100) |-> !tick) else $error("reserved clock ticks");
    a_match_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!is_pwm && counter_clear_select_bit && match_a) |=> count == 16'h0000)
        else $error("compare A match did not clear");
    a_full_period: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (period == STM_PER_FULL) |-> !match_p) else $error("period match at zero");
    a_cmp_toggle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (is_cmp && !on_rise && match_a && output_function_field == 2'b11)
        |=> pin_raw != $past(pin_raw)) else $error("toggle missed");
    a_init_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (is_cmp && on_rise) |=> pin_raw == $past(output_control_bit)) else $error("init lost");
    a_low_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ctrl0[2:0] == 3'b000) else $error("control zero low bits set");
endmodule // stm_core

//--- testbench/stm_core_test.sv
/*
 * Self-checking bench for the standard timer core: register access,
 * counting, clock sources, comparators, pin logic and interrupt.
 * Assumes stm_pkg and stm_core are compiled first; one 250 MHz clock.
 */
`timescale 1ns/10ps
module stm_core_test;
    import stm_pkg::*;
    logic clk_i;
    logic rst_n_i;
    logic high_clk_i;
    logic time_base_clk_i;
    stm_axi_req_t req;
    stm_axi_rsp_t rsp;
    logic timer_pin_o;
    logic timer_pin_oe_n_o;
    logic irq_o;
    int miscompares;
    int checks_done;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [7:0] reg_list [8] = '{STM_ADDR_CTRL0, STM_ADDR_CTRL1, STM_ADDR_CNTL, STM_ADDR_CNTH,
        STM_ADDR_CMPAL, STM_ADDR_CMPAH, STM_ADDR_PER, STM_ADDR_IRQ_STAT};

    stm_core i_stm_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .high_clk_i(high_clk_i),
        .time_base_clk_i(time_base_clk_i), .axi_req_i(req), .axi_rsp_o(rsp),
        .timer_pin_o(timer_pin_o), .timer_pin_oe_n_o(timer_pin_oe_n_o), .irq_o(irq_o));

    // ------------------------------------------------------------
    // Bus and timing tasks
    // ------------------------------------------------------------
    // Each task returns one edge after its handshake, so no signal is driven twice per step.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        logic done;
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            // Sampled mid-cycle, so the values seen are those the next edge takes.
            @(negedge clk_i);
            aw = (rsp.awready === 1'b1);
            w = (rsp.wready === 1'b1);
            done = (rsp.bvalid === 1'b1);
            @(posedge clk_i);
            if (aw) req.awvalid <= 1'b0;
            if (w) req.wvalid <= 1'b0;
        end while (!done);
        req.bready <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar;
        logic done;
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(negedge clk_i);
            ar = (rsp.arready === 1'b1);
            done = (rsp.rvalid === 1'b1);
            d = rsp.rdata;
            r = rsp.rresp;
            @(posedge clk_i);
            if (ar) req.arvalid <= 1'b0;
        end while (!done);
        req.rready <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // The time-base enable is held high for n cycles, giving n counter clocks.
    task automatic tick(input int n);
        time_base_clk_i <= 1'b1;
        repeat (n) @(posedge clk_i);
        time_base_clk_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // ------------------------------------------------------------
    // Compare tasks
    // ------------------------------------------------------------
    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_data({31'h0, got}, {31'h0, exp});
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a, rd, rr);
        check_data(rd, exp);
    endtask

    // The count is read low byte first; the timer is idle while both reads run.
    task automatic cnt_check(input logic [15:0] exp);
        logic [31:0] lo;
        axi_rd(STM_ADDR_CNTL, lo, rr);
        axi_rd(STM_ADDR_CNTH, rd, rr);
        check_data({rd[15:0], lo[7:0]}, {8'h00, exp});
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // The run needs about 67600 cycles; over twice that means a hang.
    initial begin
        #600000;
        miscompares++;
        complete_run();
    end

    initial begin
        miscompares = 0;
        checks_done = 0;
        rst_n_i = 1'b0;
        high_clk_i = 1'b0;
        time_base_clk_i = 1'b0;
        req = '0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        foreach (reg_list[i]) rd_check(reg_list[i], 32'h0000_0000);
        axi_rd(8'h40, rd, rr);
        check_data({30'h0, rr}, {30'h0, STM_RESP_SLVERR});
        axi_wr(STM_ADDR_CTRL0, 32'h0000_00FF);
        rd_check(STM_ADDR_CTRL0, 32'h0000_00F8);
        axi_wr(STM_ADDR_CTRL0, 32'h0000_0000);
        axi_wr(STM_ADDR_CNTL, 32'h0000_005A);
        axi_wr(STM_ADDR_CNTH, 32'h0000_00A5);
        cnt_check(16'h0000);
        for (int m = 0; m < 4; m++) begin
            axi_wr(STM_ADDR_CTRL1, {24'h0, 2'(m), 6'h00});
            idle(2);
            check_bit(timer_pin_oe_n_o, m[0]);
        end
        // Timer/counter mode on the time-base clock, A compare parked at the top.
        axi_wr(STM_ADDR_CMPAL, 32'h0000_00FF);
        axi_wr(STM_ADDR_CMPAH, 32'h0000_00FF);
        axi_wr(STM_ADDR_CTRL0, 32'h0000_0048);
        tick(5);
        cnt_check(16'h0005);
        axi_wr(STM_ADDR_CTRL0, 32'h0000_00C8);
        tick(4);
        cnt_check(16'h0005);
        axi_wr(STM_ADDR_CTRL0, 32'h0000_0048);
        tick(2);
        cnt_check(16'h0007);
        axi_wr(STM_ADDR_CTRL0, 32'h0000_0040);
        tick(3);
        cnt_check(16'h0007);
        axi_wr(STM_ADDR_CTRL0, 32'h0000_0048);
        cnt_check(16'h0000);
        for (int k = 5; k < 8; k++) begin
            axi_wr(STM_ADDR_CTRL0, {24'h0, 1'b0, 3'(k), 4'h8});
            tick(3);
            cnt_check(16'h0000);
        end
        // Prescaled sources are only checked for advancing, as the divider phase is free.
        for (int k = 0; k < 4; k++) begin
            axi_wr(STM_ADDR_CTRL0, 32'h0000_0040);
            axi_wr(STM_ADDR_CTRL0, {24'h0, 1'b0, 3'(k), 4'h8});
            high_clk_i <= 1'b1;
            idle(200);
            high_clk_i <= 1'b0;
            axi_rd(STM_ADDR_CNTL, rd, rr);
            check_bit(rd[7:0] != 8'h00, 1'b1);
        end
        axi_wr(STM_ADDR_CTRL0, 32'h0000_0040);
        axi_wr(STM_ADDR_CTRL0, 32'h0000_0048);
        tick(65535);
        cnt_check(16'hFFFF);
        tick(1);
        cnt_check(16'h0000);
        // Period compare of one block, interrupt raised, cleared and masked.
        axi_wr(STM_ADDR_PER, 32'h0000_0001);
        axi_wr(STM_ADDR_IRQ_CLR, 32'h0000_0003);
        axi_wr(STM_ADDR_IRQ_EN, 32'h0000_0002);
        axi_wr(STM_ADDR_CTRL0, 32'h0000_0040);
        axi_wr(STM_ADDR_CTRL0, 32'h0000_0048);
        tick(255);
        cnt_check(16'h00FF);
        rd_check(STM_ADDR_IRQ_STAT, 32'h0000_0000);
        tick(1);
        cnt_check(16'h0000);
        rd_check(STM_ADDR_IRQ_STAT, 32'h0000_0002);
        check_bit(irq_o, 1'b1);
        axi_wr(STM_ADDR_IRQ_CLR, 32'h0000_0002);
        idle(2);
        check_bit(irq_o, 1'b0);
        axi_wr(STM_ADDR_IRQ_EN, 32'h0000_0000);
        tick(256);
        rd_check(STM_ADDR_IRQ_STAT, 32'h0000_0002);
        check_bit(irq_o, 1'b0);
        // Compare output mode, A clears the counter at 3; every pin function from low.
        axi_wr(STM_ADDR_CMPAL, 32'h0000_0003);
        axi_wr(STM_ADDR_CMPAH, 32'h0000_0000);
        for (int f = 0; f < 4; f++) begin
            axi_wr(STM_ADDR_CTRL0, 32'h0000_0040);
            axi_wr(STM_ADDR_CTRL1, {24'h0, 2'b00, 2'(f), 4'b0001});
            axi_wr(STM_ADDR_CTRL0, 32'h0000_0048);
            idle(2);
            check_bit(timer_pin_o, 1'b0);
            tick(4);
            idle(2);
            check_bit(timer_pin_o, f[1]);
        end
        // Four more clocks hold exactly one further A match whichever clear timing is used.
        axi_wr(STM_ADDR_IRQ_CLR, 32'h0000_0003);
        axi_wr(STM_ADDR_IRQ_EN, 32'h0000_0001);
        tick(4);
        idle(2);
        check_bit(timer_pin_o, 1'b0);
        rd_check(STM_ADDR_IRQ_STAT, 32'h0000_0001);
        check_bit(irq_o, 1'b1);
        axi_wr(STM_ADDR_CTRL1, 32'h0000_0035);
        idle(2);
        check_bit(timer_pin_o, 1'b1);
        axi_wr(STM_ADDR_CTRL1, 32'h0000_0039);
        axi_wr(STM_ADDR_CTRL0, 32'h0000_0040);
        axi_wr(STM_ADDR_CTRL0, 32'h0000_0048);
        idle(2);
        check_bit(timer_pin_o, 1'b1);
        // PWM forced levels, active high, with and without inversion.
        for (int f = 0; f < 4; f++) begin
            axi_wr(STM_ADDR_CTRL0, 32'h0000_0040);
            axi_wr(STM_ADDR_CTRL1, {24'h0, 2'b10, 1'b0, f[1], 1'b1, f[0], 2'b00});
            axi_wr(STM_ADDR_CTRL0, 32'h0000_0048);
            idle(2);
            check_bit(timer_pin_o, f[1] ^ f[0]);
        end
        // PWM waveform: duty from A first, then duty from the period byte.
        axi_wr(STM_ADDR_CMPAL, 32'h0000_0002);
        axi_wr(STM_ADDR_CTRL0, 32'h0000_0040);
        axi_wr(STM_ADDR_CTRL1, 32'h0000_00A8);
        axi_wr(STM_ADDR_CTRL0, 32'h0000_0048);
        idle(2);
        check_bit(timer_pin_o, 1'b1);
        tick(2);
        idle(2);
        check_bit(timer_pin_o, 1'b0);
        axi_wr(STM_ADDR_CMPAH, 32'h0000_0003);
        axi_wr(STM_ADDR_CTRL0, 32'h0000_0040);
        axi_wr(STM_ADDR_CTRL1, 32'h0000_00AA);
        axi_wr(STM_ADDR_CTRL0, 32'h0000_0048);
        tick(2);
        idle(2);
        check_bit(timer_pin_o, 1'b1);
        tick(254);
        idle(2);
        check_bit(timer_pin_o, 1'b0);
        complete_run();
    end
endmodule // stm_core_test
